// ===== pkg/twu_pkg.sv
package twu_pkg;

    // Register indices; byte address is four times the index
    localparam logic [23:0] IDX_CONFIG = 24'hFFFF20;
    localparam logic [23:0] IDX_PRESCALE = 24'hFFFF22;
    localparam logic [23:0] IDX_RELOAD = 24'hFFFF24;
    localparam logic [23:0] IDX_CTRL_STATUS = 24'hFFFF26;
    localparam logic [23:0] IDX_COUNT = 24'hFFFF28;
    localparam logic [23:0] IDX_MATCH = 24'hFFFF2A;
    localparam logic [23:0] IDX_IRQ_STATUS = 24'hFFFF2C;
    localparam logic [23:0] IDX_IRQ_MASK = 24'hFFFF2E;
    localparam int unsigned MIN_ADDR_W = 26;

    // Decoded register selects
    localparam logic [2:0] SEL_CONFIG = 3'h0;
    localparam logic [2:0] SEL_PRESCALE = 3'h1;
    localparam logic [2:0] SEL_RELOAD = 3'h2;
    localparam logic [2:0] SEL_CTRL_STATUS = 3'h3;
    localparam logic [2:0] SEL_COUNT = 3'h4;
    localparam logic [2:0] SEL_MATCH = 3'h5;
    localparam logic [2:0] SEL_IRQ_STATUS = 3'h6;
    localparam logic [2:0] SEL_IRQ_MASK = 3'h7;

    // Configuration register fields
    localparam int unsigned CFG_CONFIG_LOCK = 0;
    localparam int unsigned CFG_PRESCALE_LOCK = 1;
    localparam int unsigned CFG_PERIODIC_LOCK = 2;
    localparam int unsigned CFG_COUNT_LOCK = 3;
    localparam int unsigned CFG_CLOCK_SEL = 4;
    localparam int unsigned CFG_METHOD = 5;
    localparam logic [7:0] CFG_LOCK_MASK = 8'h0F;
    localparam logic [7:0] CFG_WRITE_MASK = 8'h3F;
    localparam logic [7:0] CFG_RESET = 8'h00;

    // Prescaler register
    localparam logic [7:0] PRESCALE_MASK = 8'h07;
    localparam logic [2:0] PRESCALE_RESET = 3'h0;
    localparam logic [2:0] DIV_MAX_CODE = 3'h5;

    // Periodic control/status fields
    localparam int unsigned CTRL_RESTART = 0;
    localparam int unsigned CTRL_TC = 1;
    localparam int unsigned CTRL_TICK_IRQ_EN = 2;

    // Reset and key values
    localparam logic [15:0] RELOAD_RESET = 16'hFFFF;
    localparam logic [7:0] COUNT_RESET = 8'h0F;
    localparam logic [7:0] SERVICE_KEY = 8'h5C;

    // Interrupt status/mask fields
    localparam int unsigned IRQ_UNDERFLOW = 0;
    localparam int unsigned IRQ_EXPIRE = 1;
    localparam int unsigned IRQ_REFUSED = 2;
    localparam int unsigned IRQ_W = 3;

    // Power modes as driven on power_mode
    localparam logic [1:0] MODE_ACTIVE = 2'h0;
    localparam logic [1:0] MODE_POWER_SAVE = 2'h1;
    localparam logic [1:0] MODE_IDLE = 2'h2;
    localparam logic [1:0] MODE_HALT = 2'h3;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] RESP_DECERR = 2'h3;

endpackage

// ===== rtl/twu_timing_watchdog.sv
`timescale 1ns/10ps
// Contract
// R1: Counters keep running in power save, idle.
// R2: Only service match reachable outside active mode; the code also allows IRQ status and IRQ mask.
// R3: Halt freezes counting; resume without reload.
// R4: Software waits five slow clocks before power save.
// R5: Six registers at consecutive even indices; the code decodes eight.
// R6: Locked register: writes dropped, reads arbitrary.
// R7: Lock bits stay set until reset.
// R8: Reset clears configuration and prescaler bits.
// R9: Configuration bit layout: locks, clock select, method.
// R10: Periodic lock covers reload and control/status.
// R11: Count lock blocks count register access.
// R12: Clock select picks underflow or prescaled tick.
// R13: Method clear: count write reloads, match ignored.
// R14: Method set: key 5Ch reloads stored count.
// R15: Divisor select 0..5 divides by 1..32.
// R16: Software never programs divisor codes 110, 111.
// R17: Reserved bits read zero, ignore writes.
module twu_timing_watchdog
    import twu_pkg::*;
#(
    parameter int unsigned ADDR_W = 26
) (
    // Clock, reset, enable
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    // Device state
    input wire logic slow_clock,
    input wire logic [1:0] power_mode,
    // AXI4-Lite write address
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    // AXI4-Lite write data
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    // AXI4-Lite write response
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // AXI4-Lite read address
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    // AXI4-Lite read data
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    // Block outputs
    output logic prescaled_tick,
    output logic periodic_underflow,
    output logic wd_error,
    output logic irq
);

    if (ADDR_W < MIN_ADDR_W) begin : g_addr_check
        $error("ADDR_W too narrow for the register indices");
    end

    // Returns {hit, select} for a byte address
    // Indices below the first register wrap to large offsets and miss
    function automatic logic [3:0] decode(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] off;
        off = (a >> 2) - ADDR_W'(IDX_CONFIG);
        decode = 4'h0;
        if (a[1:0] == 2'h0 && off < ADDR_W'(16) && !off[0]) begin
            decode = {1'b1, off[3:1]}; // [R5]
        end
    endfunction

    // Access allowed given power mode and locks
    function automatic logic allowed(input logic [2:0] sel, input logic [1:0] mode,
                                     input logic [7:0] cfg);
        allowed = 1'b1;
        if (mode != MODE_ACTIVE && sel != SEL_MATCH &&
            sel != SEL_IRQ_STATUS && sel != SEL_IRQ_MASK) allowed = 1'b0; // [R2]
        unique case (sel)
            SEL_CONFIG: if (cfg[CFG_CONFIG_LOCK]) allowed = 1'b0; // [R6]
            SEL_PRESCALE: if (cfg[CFG_PRESCALE_LOCK]) allowed = 1'b0;
            SEL_RELOAD, SEL_CTRL_STATUS: if (cfg[CFG_PERIODIC_LOCK]) allowed = 1'b0; // [R10]
            SEL_COUNT: if (cfg[CFG_COUNT_LOCK]) allowed = 1'b0; // [R11]
            SEL_MATCH, SEL_IRQ_STATUS, SEL_IRQ_MASK: ;
        endcase
    endfunction

    // Last prescaler count for a divisor code; reserved codes act as 32
    function automatic logic [4:0] div_last(input logic [2:0] code);
        logic [2:0] c;
        c = (code > DIV_MAX_CODE) ? DIV_MAX_CODE : code;
        div_last = 5'((6'h01 << c) - 6'h01); // [R15]
    endfunction

    // Register state
    logic [7:0] wd_config_reg;
    logic [2:0] divisor_select;
    logic [15:0] tick_reload_reg;
    logic restart_pending;
    logic terminal_count;
    logic tick_irq_en;
    logic [7:0] wd_count_reg;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;

    // Counter state
    logic slow_prev;
    logic [4:0] div_count;
    logic [15:0] periodic_count;
    logic [7:0] wd_counter;
    logic wd_running;

    // Bus state
    logic aw_full;
    logic w_full;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;

    logic wr_fire;
    logic [3:0] wr_dec;
    logic wr_ok;
    logic ar_fire;
    logic [3:0] rd_dec;
    logic rd_ok;
    logic count_en;
    logic slow_rise;
    logic next_tick;
    logic next_underflow;
    logic wd_step;
    logic wr_count;
    logic wr_match;
    logic service_reload;
    logic bad_key;
    logic next_expire;
    logic refused_event;
    logic rd_clears_tc;

    // Halt stops counting; power save and idle do not
    assign count_en = clk_en && (power_mode != MODE_HALT); // [R1] [R3]
    assign slow_rise = slow_clock && !slow_prev;

    assign s_axi_awready = !aw_full && !s_axi_bvalid;
    assign s_axi_wready = !w_full && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign wr_fire = clk_en && aw_full && w_full && !s_axi_bvalid;
    assign ar_fire = clk_en && s_axi_arvalid && s_axi_arready;
    assign wr_dec = decode(aw_addr);
    assign rd_dec = decode(s_axi_araddr);
    assign wr_ok = wr_dec[3] && allowed(wr_dec[2:0], power_mode, wd_config_reg);
    assign rd_ok = rd_dec[3] && allowed(rd_dec[2:0], power_mode, wd_config_reg);
    assign wr_count = wr_fire && wr_ok && wr_dec[2:0] == SEL_COUNT && w_strb[0];
    assign wr_match = wr_fire && wr_ok && wr_dec[2:0] == SEL_MATCH && w_strb[0];
    assign rd_clears_tc = ar_fire && rd_ok && rd_dec[2:0] == SEL_CTRL_STATUS;
    assign refused_event = (wr_fire && wr_dec[3] && !wr_ok) ||
                           (ar_fire && rd_dec[3] && !rd_ok);

    // Servicing: method clear uses count writes, method set uses the key
    always_comb begin
        service_reload = 1'b0;
        bad_key = 1'b0;
        if (!wd_config_reg[CFG_METHOD]) begin
            service_reload = wr_count; // [R13]
        end else if (wr_match) begin
            service_reload = (w_data[7:0] == SERVICE_KEY); // [R14]
            bad_key = (w_data[7:0] != SERVICE_KEY);
        end
    end

    assign next_tick = count_en && slow_rise && div_count == div_last(divisor_select);
    assign next_underflow = next_tick && !restart_pending && periodic_count == 16'h0000;

    // Watchdog source: underflow or prescaled tick
    assign wd_step = wd_config_reg[CFG_CLOCK_SEL] ? next_tick : next_underflow; // [R12]
    assign next_expire = count_en && wd_running && wd_step && !service_reload &&
                         wd_counter == 8'h00;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            slow_prev <= 1'b0;
        end else if (clk_en) begin
            slow_prev <= slow_clock;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            div_count <= 5'h00;
        end else if (count_en && slow_rise) begin
            div_count <= next_tick ? 5'h00 : div_count + 5'h01; // [R15]
        end
    end

    // Restart loads on the next tick; reload value otherwise used at zero
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            periodic_count <= RELOAD_RESET;
        end else if (next_tick) begin
            if (restart_pending || periodic_count == 16'h0000) begin
                periodic_count <= tick_reload_reg;
            end else begin
                periodic_count <= periodic_count - 16'h0001;
            end
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            prescaled_tick <= 1'b0;
            periodic_underflow <= 1'b0;
            wd_error <= 1'b0;
        end else if (clk_en) begin
            prescaled_tick <= next_tick;
            periodic_underflow <= next_underflow;
            wd_error <= next_expire || (clk_en && bad_key);
        end
    end

    // Counter freezes at zero after expiry; the error resets the device outside
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            wd_counter <= COUNT_RESET;
            wd_running <= 1'b0;
        end else if (clk_en) begin
            if (wr_count && !wd_running) begin
                wd_running <= 1'b1;
                wd_counter <= w_data[7:0];
            end else if (service_reload) begin
                wd_running <= 1'b1;
                wd_counter <= wd_config_reg[CFG_METHOD] ? wd_count_reg : w_data[7:0];
            end else if (count_en && wd_running && wd_step && wd_counter != 8'h00) begin
                wd_counter <= wd_counter - 8'h01;
            end
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            wd_config_reg <= CFG_RESET; // [R8]
        end else if (wr_fire && wr_ok && wr_dec[2:0] == SEL_CONFIG && w_strb[0]) begin
            // Locks only ever get set; clock select and method follow the write, bits 7:6 stay zero
            wd_config_reg <= ((w_data[7:0] | wd_config_reg) & CFG_LOCK_MASK) |
                             (w_data[7:0] & CFG_WRITE_MASK & ~CFG_LOCK_MASK); // [R7] [R9] [R17]
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            divisor_select <= PRESCALE_RESET; // [R8]
        end else if (wr_fire && wr_ok && wr_dec[2:0] == SEL_PRESCALE && w_strb[0]) begin
            divisor_select <= w_data[2:0]; // [R17]
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            tick_reload_reg <= RELOAD_RESET;
        end else if (wr_fire && wr_ok && wr_dec[2:0] == SEL_RELOAD) begin
            if (w_strb[0]) tick_reload_reg[7:0] <= w_data[7:0];
            if (w_strb[1]) tick_reload_reg[15:8] <= w_data[15:8];
        end
    end

    // Restart request clears itself when the counter reloads
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            restart_pending <= 1'b0;
            tick_irq_en <= 1'b0;
        end else if (clk_en) begin
            if (wr_fire && wr_ok && wr_dec[2:0] == SEL_CTRL_STATUS && w_strb[0]) begin
                tick_irq_en <= w_data[CTRL_TICK_IRQ_EN];
                if (w_data[CTRL_RESTART]) restart_pending <= 1'b1;
                else if (next_tick) restart_pending <= 1'b0;
            end else if (next_tick) begin
                restart_pending <= 1'b0;
            end
        end
    end

    // Terminal count: set wins over the clear-on-read
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            terminal_count <= 1'b0;
        end else if (clk_en) begin
            if (next_underflow) terminal_count <= 1'b1;
            else if (rd_clears_tc) terminal_count <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            wd_count_reg <= COUNT_RESET;
        end else if (wr_count) begin
            wd_count_reg <= w_data[7:0];
        end
    end

    // Sticky events, write one to clear; a new event beats the clear
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_status <= '0;
            irq_mask <= '0;
        end else if (clk_en) begin
            if (wr_fire && wr_ok && wr_dec[2:0] == SEL_IRQ_MASK && w_strb[0]) begin
                irq_mask <= w_data[IRQ_W-1:0];
            end
            irq_status <= (irq_status &
                ~((wr_fire && wr_ok && wr_dec[2:0] == SEL_IRQ_STATUS && w_strb[0]) ?
                  w_data[IRQ_W-1:0] : {IRQ_W{1'b0}})) |
                {refused_event, next_expire, next_underflow && tick_irq_en};
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            irq <= 1'b0;
        end else if (clk_en) begin
            irq <= |(irq_status & irq_mask);
        end
    end

    // Write channel: address and data latched in either order
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            aw_addr <= '0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else if (clk_en) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_full <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_full <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (clk_en) begin
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= !wr_dec[3] ? RESP_DECERR :
                               (wr_ok ? RESP_OKAY : RESP_SLVERR); // [R6]
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Write-only and refused registers read as zero
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (clk_en) begin
            if (ar_fire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= !rd_dec[3] ? RESP_DECERR :
                               (rd_ok ? RESP_OKAY : RESP_SLVERR);
                s_axi_rdata <= 32'h0000_0000;
                if (rd_ok) begin
                    unique case (rd_dec[2:0])
                        SEL_CONFIG: s_axi_rdata <= {24'h000000, wd_config_reg}; // [R17]
                        SEL_PRESCALE: s_axi_rdata <= {29'h0, divisor_select};
                        SEL_RELOAD: s_axi_rdata <= {16'h0000, tick_reload_reg};
                        SEL_CTRL_STATUS: s_axi_rdata <= {29'h0, tick_irq_en,
                                                         terminal_count, restart_pending};
                        SEL_COUNT, SEL_MATCH: s_axi_rdata <= 32'h0000_0000;
                        SEL_IRQ_STATUS: s_axi_rdata <= {29'h0, irq_status};
                        SEL_IRQ_MASK: s_axi_rdata <= {29'h0, irq_mask};
                    endcase
                end
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule

// ===== sim/tb_twu_timing_watchdog.sv
`timescale 1ns/10ps
module tb_twu_timing_watchdog;
    import twu_pkg::*;
    localparam logic [25:0] A_CFG = {IDX_CONFIG, 2'h0}, A_PRE = {IDX_PRESCALE, 2'h0};
    localparam logic [25:0] A_REL = {IDX_RELOAD, 2'h0}, A_CTL = {IDX_CTRL_STATUS, 2'h0};
    localparam logic [25:0] A_CNT = {IDX_COUNT, 2'h0}, A_MAT = {IDX_MATCH, 2'h0};
    localparam logic [25:0] A_IST = {IDX_IRQ_STATUS, 2'h0}, A_MSK = {IDX_IRQ_MASK, 2'h0};
    logic core_clk = 0, reset_n = 0, slow_clock = 0;
    logic [1:0] power_mode = MODE_ACTIVE;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0;
    logic [25:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic prescaled_tick, periodic_underflow, wd_error, irq;
    int n_mismatch = 0, n_tests = 0, n_tick = 0, n_err = 0, cyc = 0, t0;
    integer seed = 71030;
    logic [1:0] bq[$];
    logic [33:0] rq[$];

    twu_timing_watchdog DUT (.core_clk, .reset_n, .clk_en(1'b1), .slow_clock, .power_mode,
        .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_wvalid,
        .s_axi_wready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_bvalid, .s_axi_bready,
        .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_arprot(3'h0),
        .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .prescaled_tick,
        .periodic_underflow, .wd_error, .irq);

    initial forever #4 core_clk = ~core_clk;

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [33:0] g, input logic [33:0] e);
        n_tests++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR at %0t got %h expected %h", $time, g, e);
        end
    endtask

    // Slow clock rising edge every 4 core cycles; event counters; hang guard
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc[0])
            slow_clock <= ~slow_clock;
        if (prescaled_tick)
            n_tick <= n_tick + 1;
        if (wd_error)
            n_err <= n_err + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            give_verdict();
        end
    end

    // Bus answers are matched against the oldest expectation
    always @(posedge core_clk) begin
        if (s_axi_bvalid && s_axi_bready)
            chk({32'h0, s_axi_bresp}, {32'h0, bq.pop_front()});
        if (s_axi_rvalid && s_axi_rready)
            chk({s_axi_rdata, s_axi_rresp}, rq.pop_front());
    end

    task automatic wr(input logic [25:0] a, input logic [31:0] v, input logic [1:0] r);
        logic aw = 1'b0, w = 1'b0;
        bq.push_back(r);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw && w)) begin
            @(posedge core_clk);
            if (!aw && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (!w && s_axi_wready)
                s_axi_wvalid <= 1'b0;
            aw = aw || s_axi_awready;
            w = w || s_axi_wready;
        end
        do @(posedge core_clk); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic rd(input logic [25:0] a, input logic [31:0] v, input logic [1:0] r);
        rq.push_back({v, r});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge core_clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge core_clk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        @(posedge core_clk);
    endtask

    initial begin
        repeat (5) @(posedge core_clk);
        reset_n <= 1'b1;
        @(posedge core_clk);
        rd(A_CFG, 0, RESP_OKAY);
        rd(A_PRE, 0, RESP_OKAY);
        rd(A_REL, 32'hFFFF, RESP_OKAY);
        rd(A_CNT, 0, RESP_OKAY);
        rd(A_CFG + 26'h1, 0, RESP_DECERR);
        wr(A_CFG + 26'h4, 0, RESP_DECERR);
        d = $random(seed);
        wr(A_CFG, d & 32'hF0, RESP_OKAY);
        rd(A_CFG, d & 32'h30, RESP_OKAY);
        wr(A_PRE, (d & 32'hF8) | 32'h5, RESP_OKAY);
        rd(A_PRE, 32'h5, RESP_OKAY);
        wr(A_REL, d | 32'h1, RESP_OKAY);
        rd(A_REL, (d | 32'h1) & 32'hFFFF, RESP_OKAY);
        wr(A_CFG, 0, RESP_OKAY);
        $display("register map test done");
        // Every legal divisor, counted over a whole number of periods, in all running modes
        for (int k = 0; k < 6; k++) begin
            power_mode <= MODE_ACTIVE;
            wr(A_PRE, k, RESP_OKAY);
            power_mode <= (k % 3 == 0) ? MODE_ACTIVE : (k % 3 == 1) ? MODE_POWER_SAVE : MODE_IDLE;
            repeat (256) @(posedge core_clk);
            t0 = n_tick;
            repeat (256) @(posedge core_clk);
            chk(34'(n_tick - t0), 34'(64 >> k));
        end
        power_mode <= MODE_ACTIVE;
        wr(A_PRE, 0, RESP_OKAY);
        power_mode <= MODE_HALT;
        repeat (3) @(posedge core_clk);
        t0 = n_tick;
        repeat (40) @(posedge core_clk);
        chk(34'(n_tick - t0), 34'h0);
        $display("prescaler test done");
        power_mode <= MODE_POWER_SAVE;
        rd(A_CFG, 0, RESP_SLVERR);
        wr(A_PRE, 1, RESP_SLVERR);
        wr(A_MAT, 32'h5D, RESP_OKAY);
        rd(A_IST, 32'h4, RESP_OKAY);
        chk({33'h0, irq}, 34'h0);
        wr(A_MSK, 32'h4, RESP_OKAY);
        repeat (3) @(posedge core_clk);
        chk({33'h0, irq}, 34'h1);
        wr(A_IST, 32'h4, RESP_OKAY);
        repeat (3) @(posedge core_clk);
        chk({33'h0, irq}, 34'h0);
        power_mode <= MODE_ACTIVE;
        $display("power mode test done");
        wr(A_REL, 32'hFFFF, RESP_OKAY);
        wr(A_CTL, 32'h1, RESP_OKAY);
        t0 = n_err;
        wr(A_CNT, 32'h2, RESP_OKAY);
        repeat (20) @(posedge core_clk);
        wr(A_MAT, 32'h5D, RESP_OKAY);
        repeat (100) @(posedge core_clk);
        chk(34'(n_err - t0), 34'h0);
        wr(A_CFG, 32'h10, RESP_OKAY);
        repeat (40) @(posedge core_clk);
        chk(34'(n_err != t0), 34'h1);
        wr(A_CNT, 32'h20, RESP_OKAY);
        t0 = n_err;
        repeat (60) @(posedge core_clk);
        wr(A_CNT, 32'h20, RESP_OKAY);
        repeat (60) @(posedge core_clk);
        chk(34'(n_err - t0), 34'h0);
        wr(A_CFG, 32'h30, RESP_OKAY);
        t0 = n_err;
        wr(A_MAT, SERVICE_KEY, RESP_OKAY);
        repeat (100) @(posedge core_clk);
        wr(A_MAT, 32'h5D, RESP_OKAY);
        repeat (3) @(posedge core_clk);
        chk(34'(n_err - t0), 34'h1);
        $display("watchdog test done");
        wr(A_CFG, 32'h34, RESP_OKAY);
        wr(A_REL, 32'h1, RESP_SLVERR);
        rd(A_CTL, 0, RESP_SLVERR);
        wr(A_PRE, 32'h2, RESP_OKAY);
        wr(A_CFG, 32'h3B, RESP_OKAY);
        rd(A_CFG, 0, RESP_SLVERR);
        wr(A_CFG, 0, RESP_SLVERR);
        wr(A_PRE, 32'h1, RESP_SLVERR);
        wr(A_CNT, 32'h9, RESP_SLVERR);
        wr(A_MAT, SERVICE_KEY, RESP_OKAY);
        reset_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        reset_n <= 1'b1;
        @(posedge core_clk);
        rd(A_CFG, 0, RESP_OKAY);
        rd(A_PRE, 0, RESP_OKAY);
        $display("lock test done");
        give_verdict();
    end
endmodule

// ===== sim/twu_tw_properties.sv
`timescale 1ns/10ps
module twu_tw_properties
    import twu_pkg::*;
#(
    parameter int unsigned ADDR_W = 26
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Device state
    input wire logic [1:0] power_mode,
    // Register bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    // Timing outputs
    input wire logic prescaled_tick,
    input wire logic periodic_underflow
);
    localparam logic [ADDR_W-1:0] A_CFG = {IDX_CONFIG, 2'h0};
    localparam logic [ADDR_W-1:0] A_CNT = {IDX_COUNT, 2'h0};
    logic ar_take;
    assign ar_take = s_axi_arvalid && !s_axi_rvalid;

    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
        s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write response missing");
    a_read_answer: assert property (ar_take |=> s_axi_rvalid)
        else $error("read response missing");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
    a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    a_unaligned_read: assert property (ar_take && s_axi_araddr[1:0] != 2'h0 |=>
        s_axi_rresp == RESP_DECERR) else $error("unaligned read not decode error");
    a_count_hidden: assert property (ar_take && s_axi_araddr == A_CNT |=>
        s_axi_rdata == 32'h0) else $error("count register readable");
    a_mode_refuse: assert property (ar_take && power_mode != MODE_ACTIVE &&
        s_axi_araddr == A_CFG |=> s_axi_rresp == RESP_SLVERR) else $error("access outside active");
    a_halt_freeze: assert property ((power_mode == MODE_HALT)[*3] |->
        !prescaled_tick && !periodic_underflow) else $error("counting during halt");
    a_tick_pulse: assert property (prescaled_tick |=> !prescaled_tick)
        else $error("tick longer than one cycle");

    c_slverr: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
    c_halt: cover property ((power_mode == MODE_HALT)[*3]);
    c_tick: cover property (prescaled_tick);
endmodule

bind twu_timing_watchdog twu_tw_properties #(.ADDR_W(ADDR_W)) u_props (.core_clk, .reset_n,
    .power_mode, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp, .prescaled_tick, .periodic_underflow);
